/* rtl/interlock_pkg.sv */
package interlock_pkg;

  // Timing.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int unsigned MATCH_S = 30;
  localparam logic [4:0] MATCH_TICKS = 5'(MATCH_S / TICK_S);

  // Limits.
  localparam logic [15:0] WINDOW_MAX = 16'hFFFF;
  localparam logic [4:0] THRESH_MAX = 5'h10;

  // Register offsets (byte addresses).
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WINDOW = 8'h04;
  localparam logic [7:0] REG_THRESH = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;

  // Reset values.
  localparam logic [15:0] WINDOW_RST = 16'h0000;
  localparam logic [4:0] THRESH_RST = 5'h00;
  localparam logic OVERRIDE_RST = 1'b0;

  // Field positions.
  localparam int unsigned CTRL_OVERRIDE_BIT = 0;
  localparam int unsigned STAT_FLAG_BIT = 8;
  localparam int unsigned STAT_ENABLED_BIT = 9;
  localparam int unsigned STAT_LEVER_BIT = 10;
  localparam int unsigned STAT_SESSION_BIT = 11;
  localparam int unsigned STAT_REMOTE_BIT = 12;

  // Interrupt event bits.
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_EXCESS = 0;
  localparam int unsigned EV_DROPPED = 1;
  localparam int unsigned EV_FAILED = 2;
  localparam int unsigned EV_REFUSED = 3;

  // Protection modes.
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PROT_OFF = 3'h1;
  localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h2;
  localparam logic [2:0] MODE_FAST_SINGLE = 3'h3;
  localparam logic [2:0] MODE_FAST = 3'h4;

  typedef enum logic [1:0] {
    SRC_SCADA = 2'h0,
    SRC_PANEL = 2'h1,
    SRC_CONTROLLER = 2'h2
  } cmd_src_t;

  // A request from the supervisory master or the panel.
  typedef struct packed {
    logic valid;
    logic dummy;
    logic [2:0] mode;
  } mode_req_t;

  // A command towards the reclosers.
  typedef struct packed {
    logic valid;
    logic dummy;
    logic [2:0] mode;
    cmd_src_t src;
  } mode_cmd_t;

  typedef enum logic [2:0] {
    MON_IDLE = 3'b001,
    MON_CHECK = 3'b010,
    MON_ISSUE = 3'b100
  } mon_state_t;

endpackage : interlock_pkg

/* rtl/fault_window.sv */
`timescale 1ns/1ps

// Sliding window of time-stamped line faults; each slot ages on the seconds tick.
module fault_window #(
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic secTick,
  input wire logic clear,
  input wire logic add,
  input wire logic [15:0] windowSec,
  // Result.
  output logic [4:0] count
);

  logic [DEPTH-1:0] slotValid_r;
  logic [15:0] slotAge_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wrPtr_r;
  logic [4:0] count_nxt;

  always_comb begin
    count_nxt = 5'h00;
    for (int i = 0; i < DEPTH; i++) begin
      count_nxt = count_nxt + 5'(slotValid_r[i]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gSlot
      wire logic isNew = add && (wrPtr_r == ($clog2(DEPTH))'(g));
      wire logic aged = secTick && slotValid_r[g] && (slotAge_r[g] + 16'h0001 >= windowSec);
      always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
          slotValid_r[g] <= 1'b0;
          slotAge_r[g] <= 16'h0000;
        end else if (isNew) begin
          slotValid_r[g] <= 1'b1;
          slotAge_r[g] <= 16'h0000;
        end else if (aged) begin
          slotValid_r[g] <= 1'b0;
        end else if (secTick && slotValid_r[g]) begin
          slotAge_r[g] <= slotAge_r[g] + 16'h0001;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      wrPtr_r <= '0;
      count <= 5'h00;
    end else begin
      if (add) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      count <= count_nxt;
    end
  end

endmodule : fault_window

/* rtl/control_interlock_fault_rate_monitor.sv */
`timescale 1ns/1ps

module control_interlock_fault_rate_monitor #(
  parameter int unsigned NREC = 3,
  parameter int unsigned NPHASE = 3,
  parameter int unsigned TICK_CYCLES = interlock_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins from the pole.
  input wire logic [NREC-1:0] leverDown,
  input wire logic sessionActive,
  input wire logic remoteOn,
  input wire logic [3*NREC-1:0] activeMode,
  // Requests and recloser events from the protocol logic.
  input wire interlock_pkg::mode_req_t scadaReq,
  input wire interlock_pkg::mode_req_t panelReq,
  input wire logic [NPHASE-1:0] faultCleared,
  input wire logic cmdBusy,
  input wire logic cmdFail,
  // Command and answers.
  output interlock_pkg::mode_cmd_t cmdOut,
  output logic scadaRefused,
  output logic panelRefused,
  output logic excessFlag,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [NREC-1:0] leverMeta_r, leverSync_r;
  logic sessMeta_r, sessSync_r, remMeta_r, remSync_r;
  logic [3*NREC-1:0] modeMeta_r, modeSync_r, modePrev_r;
  logic [1:0] modeArm_r;
  logic modePrevValid_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      leverMeta_r <= '0;
      leverSync_r <= '0;
      sessMeta_r <= 1'b0;
      sessSync_r <= 1'b0;
      remMeta_r <= 1'b0;
      remSync_r <= 1'b0;
      modeMeta_r <= '0;
      modeSync_r <= '0;
    end else begin
      leverMeta_r <= leverDown;
      leverSync_r <= leverMeta_r;
      sessMeta_r <= sessionActive;
      sessSync_r <= sessMeta_r;
      remMeta_r <= remoteOn;
      remSync_r <= remMeta_r;
      modeMeta_r <= activeMode;
      modeSync_r <= modeMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic override_r;
  logic [15:0] window_r;
  logic [4:0] thresh_r;
  logic [interlock_pkg::IRQ_W-1:0] irqStat_r, irqMask_r, irqSet;
  logic [4:0] faultCount;

  wire logic busReq = cyc_i && stb_i && !ack_o;
  wire logic busWr = busReq && we_i;
  wire logic [31:0] wMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire logic [31:0] wData = dat_i & wMask;
  wire logic wrCtrl = busWr && (adr_i == interlock_pkg::REG_CTRL);
  wire logic wrWindow = busWr && (adr_i == interlock_pkg::REG_WINDOW);
  wire logic wrThresh = busWr && (adr_i == interlock_pkg::REG_THRESH);
  wire logic wrIrqStat = busWr && (adr_i == interlock_pkg::REG_IRQ_STAT);
  wire logic wrIrqMask = busWr && (adr_i == interlock_pkg::REG_IRQ_MASK);
  wire logic [15:0] windowWr = (window_r & ~wMask[15:0]) | wData[15:0];
  wire logic [4:0] threshIn = sel_i[0] ? wData[4:0] : thresh_r;
  // Larger thresholds are clamped to the supported maximum.
  wire logic [4:0] threshWr = (threshIn > interlock_pkg::THRESH_MAX) ?
                              interlock_pkg::THRESH_MAX : threshIn;
  wire logic monEnabled = (thresh_r != 5'h00) && (window_r != 16'h0000);
  wire logic leverAny = |leverSync_r;

  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[4:0] = faultCount;
    statusWord[interlock_pkg::STAT_FLAG_BIT] = excessFlag;
    statusWord[interlock_pkg::STAT_ENABLED_BIT] = monEnabled;
    statusWord[interlock_pkg::STAT_LEVER_BIT] = leverAny;
    statusWord[interlock_pkg::STAT_SESSION_BIT] = sessSync_r;
    statusWord[interlock_pkg::STAT_REMOTE_BIT] = remSync_r;
  end

  wire logic [31:0] rdData =
    (adr_i == interlock_pkg::REG_CTRL) ? {31'h0000_0000, override_r} :
    (adr_i == interlock_pkg::REG_WINDOW) ? {16'h0000, window_r} :
    (adr_i == interlock_pkg::REG_THRESH) ? {27'h000_0000, thresh_r} :
    (adr_i == interlock_pkg::REG_STATUS) ? statusWord :
    (adr_i == interlock_pkg::REG_IRQ_STAT) ? {28'h000_0000, irqStat_r} :
    (adr_i == interlock_pkg::REG_IRQ_MASK) ? {28'h000_0000, irqMask_r} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      override_r <= interlock_pkg::OVERRIDE_RST;
      window_r <= interlock_pkg::WINDOW_RST;
      thresh_r <= interlock_pkg::THRESH_RST;
      irqMask_r <= '0;
    end else begin
      ack_o <= busReq;
      dat_o <= (busReq && !we_i) ? rdData : 32'h0000_0000;
      if (wrCtrl && sel_i[0]) begin
        override_r <= dat_i[interlock_pkg::CTRL_OVERRIDE_BIT];
      end
      if (wrWindow) begin
        window_r <= windowWr;
      end
      if (wrThresh) begin
        thresh_r <= threshWr;
      end
      if (wrIrqMask && sel_i[0]) begin
        irqMask_r <= dat_i[interlock_pkg::IRQ_W-1:0];
      end
    end
  end

  // Hardware set wins over a write-one clear in the same cycle.
  wire logic [interlock_pkg::IRQ_W-1:0] irqClr =
    (wrIrqStat && sel_i[0]) ? dat_i[interlock_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_r <= '0;
      irq <= 1'b0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqMask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Seconds tick and mode-change detection.

  logic [$clog2(TICK_CYCLES)-1:0] tickCnt_r;
  logic secTick_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_r <= '0;
      secTick_r <= 1'b0;
    end else begin
      secTick_r <= (tickCnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
      tickCnt_r <= (tickCnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) ?
                   '0 : tickCnt_r + 1'b1;
    end
  end

  // Comparison starts only once the synchroniser holds a real pin sample.
  // Otherwise a non-zero mode at reset release would look like a change.
  wire logic modeChanged = modePrevValid_r && (modeSync_r != modePrev_r);
  wire logic windowClear = modeChanged || !monEnabled;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modePrev_r <= '0;
      modeArm_r <= 2'h0;
      modePrevValid_r <= 1'b0;
    end else begin
      modePrev_r <= modeSync_r;
      modeArm_r <= {modeArm_r[0], 1'b1};
      modePrevValid_r <= modeArm_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase matching of cleared faults.

  logic [NPHASE-1:0] phaseSeen_r;
  logic [4:0] matchLeft_r;

  wire logic faultAny = |faultCleared;
  wire logic matchOpen = (matchLeft_r != 5'h00);
  // A fault merges only if every reporting phase is new to the open match interval.
  wire logic merges = matchOpen && ((faultCleared & phaseSeen_r) == '0);
  wire logic newLineFault = faultAny && !merges && monEnabled && !modeChanged;

  // A merge must not swallow a tick, or the matching interval would stretch.
  always_ff @(posedge clk) begin
    if (!rst_n || windowClear) begin
      phaseSeen_r <= '0;
      matchLeft_r <= 5'h00;
    end else if (newLineFault) begin
      phaseSeen_r <= faultCleared;
      matchLeft_r <= interlock_pkg::MATCH_TICKS;
    end else begin
      if (faultAny && merges) begin
        phaseSeen_r <= phaseSeen_r | faultCleared;
      end
      if (secTick_r && matchOpen) begin
        matchLeft_r <= matchLeft_r - 5'h01;
      end
    end
  end

  // One slot per countable fault, so the count can reach the largest threshold.
  fault_window #(
    .DEPTH(16)
  ) uWindow (
    .clk(clk),
    .rst_n(rst_n),
    .secTick(secTick_r),
    .clear(windowClear),
    .add(newLineFault),
    .windowSec(window_r),
    .count(faultCount)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Excess monitor: check after a new line fault that arrives in MON_IDLE, then try one command.

  interlock_pkg::mon_state_t monState_r, monState_nxt;
  wire logic overThresh = monEnabled && (faultCount >= thresh_r);
  wire logic blocked = leverAny || sessSync_r || cmdBusy || cmdOut.valid;

  always_comb begin
    case (monState_r)
      interlock_pkg::MON_IDLE: begin
        monState_nxt = newLineFault ? interlock_pkg::MON_CHECK : interlock_pkg::MON_IDLE;
      end
      interlock_pkg::MON_CHECK: begin
        // Wait one cycle so the window count includes the new fault.
        monState_nxt = interlock_pkg::MON_ISSUE;
      end
      interlock_pkg::MON_ISSUE: begin
        monState_nxt = interlock_pkg::MON_IDLE;
      end
      default: begin
        monState_nxt = interlock_pkg::MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      monState_r <= interlock_pkg::MON_IDLE;
    end else begin
      monState_r <= monState_nxt;
    end
  end

  // A firing that finds the line blocked is dropped, never queued.
  wire logic monFire = (monState_r == interlock_pkg::MON_ISSUE) && overThresh;
  wire logic monGo = monFire && !blocked;
  wire logic monDrop = monFire && blocked;

  ////////////////////////////////////////////////////////////////////////////////
  // Request interlock and command output.

  wire logic clearToAct = !leverAny && !sessSync_r;
  wire logic scadaOk = scadaReq.dummy || (clearToAct && remSync_r);
  wire logic panelOk = clearToAct && (!remSync_r || override_r);
  wire logic scadaGo = scadaReq.valid && scadaOk && !monFire && !cmdBusy && !cmdOut.valid;
  wire logic panelGo = panelReq.valid && panelOk && !monFire && !scadaReq.valid &&
                       !cmdBusy && !cmdOut.valid;

  interlock_pkg::mode_cmd_t cmd_nxt;
  always_comb begin
    cmd_nxt = '0;
    if (monGo) begin
      cmd_nxt.valid = 1'b1;
      cmd_nxt.mode = interlock_pkg::MODE_PROT_OFF;
      cmd_nxt.src = interlock_pkg::SRC_CONTROLLER;
    end else if (scadaGo) begin
      cmd_nxt.valid = 1'b1;
      cmd_nxt.dummy = scadaReq.dummy;
      cmd_nxt.mode = scadaReq.mode;
      cmd_nxt.src = interlock_pkg::SRC_SCADA;
    end else if (panelGo) begin
      cmd_nxt.valid = 1'b1;
      cmd_nxt.mode = panelReq.mode;
      cmd_nxt.src = interlock_pkg::SRC_PANEL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdOut <= '0;
      scadaRefused <= 1'b0;
      panelRefused <= 1'b0;
      excessFlag <= 1'b0;
    end else begin
      cmdOut <= cmd_nxt;
      scadaRefused <= scadaReq.valid && !scadaGo;
      panelRefused <= panelReq.valid && !panelGo;
      if (monFire) begin
        excessFlag <= 1'b1;
      end else if (modeChanged) begin
        excessFlag <= 1'b0;
      end
    end
  end

  always_comb begin
    irqSet = '0;
    irqSet[interlock_pkg::EV_EXCESS] = monFire;
    irqSet[interlock_pkg::EV_DROPPED] = monDrop;
    irqSet[interlock_pkg::EV_FAILED] = cmdFail;
    irqSet[interlock_pkg::EV_REFUSED] = (scadaReq.valid && !scadaGo) ||
                                        (panelReq.valid && !panelGo);
  end

endmodule : control_interlock_fault_rate_monitor

/* bench/interlock_monitor.sv */
`timescale 1ns/1ps

module interlock_monitor #(
  parameter int unsigned NREC = 3,
  parameter int unsigned NPHASE = 3,
  parameter int unsigned TICK_CYCLES = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins and requests.
  input wire logic [NREC-1:0] leverDown,
  input wire logic sessionActive,
  input wire logic remoteOn,
  input wire logic [3*NREC-1:0] activeMode,
  input wire interlock_pkg::mode_req_t scadaReq,
  input wire interlock_pkg::mode_req_t panelReq,
  input wire logic [NPHASE-1:0] faultCleared,
  input wire logic cmdBusy,
  input wire logic cmdFail,
  // Answers.
  input wire interlock_pkg::mode_cmd_t cmdOut,
  input wire logic scadaRefused,
  input wire logic panelRefused,
  input wire logic excessFlag,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  bus_ack_a:
  assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack timing");
  lever_lock_a:
  assert property ((|leverDown)[*6] ##0 (scadaReq.valid || panelReq.valid) |=>
    !cmdOut.valid || cmdOut.dummy)
    else $error("grant with lever down");
  session_lock_a:
  assert property (sessionActive[*6] ##0 panelReq.valid |=>
    panelRefused && (!cmdOut.valid || cmdOut.dummy))
    else $error("grant in session");
  remote_off_a:
  assert property ((!remoteOn)[*6] ##0 scadaReq.valid && !scadaReq.dummy |=> scadaRefused)
    else $error("supervisory grant with remote off");
  dummy_pass_a:
  assert property ((leverDown == '0 && !sessionActive && faultCleared == '0)[*6] ##0
    (scadaReq.valid && scadaReq.dummy && !cmdBusy && !cmdOut.valid) |=>
    cmdOut.valid && cmdOut.dummy && cmdOut.src == interlock_pkg::SRC_SCADA)
    else $error("dummy control refused");
  grant_space_a:
  assert property (cmdOut.valid |=> !cmdOut.valid) else $error("command not a pulse");
  busy_block_a:
  assert property (cmdOut.valid |-> !$past(cmdBusy)) else $error("command while busy");
  self_source_a:
  assert property (cmdOut.valid && cmdOut.src == interlock_pkg::SRC_CONTROLLER |->
    cmdOut.mode == interlock_pkg::MODE_PROT_OFF && !cmdOut.dummy && excessFlag)
    else $error("own command malformed");
  flag_cause_a:
  assert property ($rose(excessFlag) |-> $past(faultCleared, 3) != '0)
    else $error("flag without fault");
  mode_clear_a:
  assert property ($changed(activeMode) && faultCleared == '0 |-> ##[1:6] !excessFlag)
    else $error("flag kept after mode change");
endmodule : interlock_monitor

bind control_interlock_fault_rate_monitor interlock_monitor #(
  .NREC(NREC), .NPHASE(NPHASE), .TICK_CYCLES(TICK_CYCLES)
) u_mon (
  .clk, .rst_n, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
  .leverDown, .sessionActive, .remoteOn, .activeMode, .scadaReq, .panelReq,
  .faultCleared, .cmdBusy, .cmdFail, .cmdOut, .scadaRefused, .panelRefused,
  .excessFlag, .irq
);

/* bench/recloser_line_model.sv */
`timescale 1ns/1ps

module recloser_line_model #(
  parameter int unsigned NREC = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Command side.
  input wire interlock_pkg::mode_cmd_t cmdOut,
  input wire logic failNext,
  // Recloser state.
  output logic [3*NREC-1:0] activeMode,
  output logic cmdFail
);
  // A delivered non-dummy command moves every recloser; a lost one only reports failure.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      activeMode <= '0;
      cmdFail <= 1'b0;
    end else begin
      cmdFail <= cmdOut.valid && failNext;
      if (cmdOut.valid && !failNext && !cmdOut.dummy) begin
        activeMode <= {NREC{cmdOut.mode}};
      end
    end
  end
endmodule : recloser_line_model

/* bench/control_interlock_fault_rate_monitor_tb_top.sv */
`timescale 1ns/1ps

`define CHK(a, b) begin \
  samplesChecked++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); \
  end \
end

module control_interlock_fault_rate_monitor_tb_top;
  localparam int unsigned TICK = 8;
  logic clk, rst_n, wbCyc, wbStb, wbWe, ack, seen;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbWdat, datO, q;
  logic [2:0] leverDown, faultCleared;
  logic sessionActive, remoteOn, cmdBusy, failNext, cmdFail;
  logic [8:0] activeMode;
  interlock_pkg::mode_req_t scadaReq, panelReq;
  interlock_pkg::mode_cmd_t cmdOut;
  logic scadaRefused, panelRefused, excessFlag, irq;
  logic [5:0] rows [5];
  int fails = 0;
  int samplesChecked = 0;
  int cycles = 0;

  control_interlock_fault_rate_monitor #(.TICK_CYCLES(TICK)) u_dut (
    .clk, .rst_n, .cyc_i(wbCyc), .stb_i(wbStb), .we_i(wbWe), .adr_i(wbAdr),
    .sel_i(wbSel), .dat_i(wbWdat), .dat_o(datO), .ack_o(ack), .leverDown,
    .sessionActive, .remoteOn, .activeMode, .scadaReq, .panelReq, .faultCleared,
    .cmdBusy, .cmdFail, .cmdOut, .scadaRefused, .panelRefused, .excessFlag, .irq
  );
  recloser_line_model u_line (.clk, .rst_n, .cmdOut, .failNext, .activeMode, .cmdFail);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("fails=%0d checked=%0d", fails, samplesChecked);
    if (fails == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbWdat} <= {1'b1, 1'b1, w, 4'hF, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = datO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q & m, e)
  endtask : rdChk

  task automatic req(input logic pnl, input logic dum, input logic e);
    repeat (2) @(posedge clk);
    if (pnl) panelReq <= '{1'b1, dum, 3'h4};
    else scadaReq <= '{1'b1, dum, 3'h4};
    @(posedge clk);
    scadaReq <= '0;
    panelReq <= '0;
    #1;
    `CHK(cmdOut.valid, e)
    `CHK(pnl ? panelRefused : scadaRefused, !e)
  endtask : req

  task automatic fault(input logic [2:0] ph);
    @(posedge clk);
    faultCleared <= ph;
    @(posedge clk);
    faultCleared <= '0;
  endtask : fault

  task automatic waitCmd(output logic s);
    s = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (cmdOut.valid === 1'b1 && !s) begin
        s = 1'b1;
        `CHK(cmdOut.src, interlock_pkg::SRC_CONTROLLER)
        `CHK(cmdOut.mode, interlock_pkg::MODE_PROT_OFF)
        `CHK(excessFlag, 1'b1)
      end
    end
  endtask : waitCmd

  initial begin
    {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbWdat, wbSel} = '0;
    {leverDown, faultCleared, sessionActive, remoteOn, cmdBusy, failNext} = '0;
    scadaReq = '0;
    panelReq = '0;
    rows = '{6'b101100, 6'b011100, 6'b001010, 6'b001111, 6'b000001};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(interlock_pkg::REG_THRESH, 32'hFFFFFFFF, 32'h0);
    rdChk(8'h40, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, interlock_pkg::REG_THRESH, 32'h1F);
    rdChk(interlock_pkg::REG_THRESH, 32'h1F, 32'h10);
    wb(1'b1, interlock_pkg::REG_WINDOW, 32'hFFFF);
    rdChk(interlock_pkg::REG_WINDOW, 32'hFFFF, 32'hFFFF);
    foreach (rows[i]) begin
      @(posedge clk);
      {leverDown[0], sessionActive, remoteOn} <= rows[i][5:3];
      wb(1'b1, interlock_pkg::REG_CTRL, {31'h0, rows[i][2]});
      req(1'b0, 1'b0, rows[i][1]);
      req(1'b1, 1'b0, rows[i][0]);
    end
    req(1'b0, 1'b1, 1'b1);
    rdChk(interlock_pkg::REG_IRQ_STAT, 32'h8, 32'h8);
    wb(1'b1, interlock_pkg::REG_IRQ_STAT, 32'hF);
    // Two phases merge into one line fault; a repeated phase is a new one.
    wb(1'b1, interlock_pkg::REG_THRESH, 32'h2);
    wb(1'b1, interlock_pkg::REG_WINDOW, 32'h64);
    fault(3'h1);
    repeat (5) @(posedge clk);
    fault(3'h2);
    rdChk(interlock_pkg::REG_STATUS, 32'h1F, 32'h1);
    fault(3'h1);
    waitCmd(seen);
    `CHK(seen, 1'b1)
    `CHK(irq, 1'b0)
    wb(1'b1, interlock_pkg::REG_IRQ_MASK, 32'h1);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    wb(1'b1, interlock_pkg::REG_IRQ_STAT, 32'h1);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    rdChk(interlock_pkg::REG_STATUS, 32'h11F, 32'h0);
    // A blocked command is lost, then retried on the next fault.
    wb(1'b1, interlock_pkg::REG_THRESH, 32'h1);
    @(posedge clk);
    cmdBusy <= 1'b1;
    fault(3'h4);
    waitCmd(seen);
    `CHK(seen, 1'b0)
    rdChk(interlock_pkg::REG_IRQ_STAT, 32'h2, 32'h2);
    @(posedge clk);
    {cmdBusy, failNext} <= 2'b01;
    fault(3'h4);
    waitCmd(seen);
    `CHK(seen, 1'b1)
    rdChk(interlock_pkg::REG_IRQ_STAT, 32'h4, 32'h4);
    wb(1'b1, interlock_pkg::REG_WINDOW, 32'h0);
    fault(3'h1);
    rdChk(interlock_pkg::REG_STATUS, 32'h21F, 32'h0);
    // A fault leaves the count once older than the window.
    wb(1'b1, interlock_pkg::REG_THRESH, 32'h10);
    wb(1'b1, interlock_pkg::REG_WINDOW, 32'h2);
    fault(3'h1);
    rdChk(interlock_pkg::REG_STATUS, 32'h21F, 32'h201);
    repeat (4 * TICK) @(posedge clk);
    rdChk(interlock_pkg::REG_STATUS, 32'h1F, 32'h0);
    complete_run();
  end
endmodule : control_interlock_fault_rate_monitor_tb_top
